// >>> logic/clk_evt_pkg.sv
`default_nettype none
package clk_evt_pkg;

    // --------------------------------------------------------------------
    // Register map (byte addresses)
    // --------------------------------------------------------------------
    localparam int          ADDR_W        = 12;
    localparam int          RATE_W        = 16;
    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_RATE      = 12'h004;
    localparam logic [11:0] OFF_FLAGS     = 12'h008;
    localparam logic [11:0] OFF_ENABLE    = 12'h00C;
    localparam logic [11:0] OFF_STATE     = 12'h010;
    localparam logic [11:0] OFF_PLL_CFG   = 12'h014;

    // --------------------------------------------------------------------
    // Control register fields
    // --------------------------------------------------------------------
    localparam int CTRL_SRC_SEL   = 0;
    localparam int CTRL_PSTOP_SEL = 1;
    localparam int CTRL_OSC_PSTOP = 2;
    localparam int CTRL_OSC_EN    = 3;
    localparam int CTRL_W         = 4;

    // --------------------------------------------------------------------
    // Flag and enable layout, shared
    // --------------------------------------------------------------------
    localparam int EV_TIMER = 0;
    localparam int EV_LOCK  = 1;
    localparam int EV_OSC   = 2;
    localparam int EV_LV    = 3;
    localparam int EV_W     = 4;

    // --------------------------------------------------------------------
    // State register fields
    // --------------------------------------------------------------------
    localparam int ST_LOCK   = 0;
    localparam int ST_OSC_UP = 1;
    localparam int ST_LVDS   = 2;
    localparam int ST_W      = 3;
    localparam int PLL_CFG_W = 8;

    // --------------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------------
    localparam logic [CTRL_W-1:0]    CTRL_RST    = 4'h0;
    localparam logic [RATE_W-1:0]    RATE_RST    = 16'h0000;
    localparam logic [EV_W-1:0]      EV_RST      = 4'h0;
    localparam logic [PLL_CFG_W-1:0] PLL_CFG_RST = 8'h00;
    localparam logic [31:0]          RDATA_RST   = 32'h0000_0000;

endpackage : clk_evt_pkg
`default_nettype wire

// >>> logic/timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
    import clk_evt_pkg::*;
    logic              tick;
    logic              run;
    logic              restart;
    logic [RATE_W-1:0] period;
    logic              expire;
    logic [RATE_W-1:0] count;

    modport ctrl  (output tick, run, restart, period, input expire, count);
    modport timer (input tick, run, restart, period, output expire, count);
endinterface : timer_if
`default_nettype wire

// >>> logic/signal_sync.sv
`timescale 1ns/1ps
`default_nettype none
module signal_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Asynchronous input
    input  wire logic async_in,
    // Synchronised view
    output logic      level,
    output logic      rise,
    output logic      change
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level  = sync_q;
    assign rise   = sync_q & ~prev_q;
    assign change = sync_q ^ prev_q;
endmodule : signal_sync
`default_nettype wire

// >>> logic/periodic_timer.sv
`timescale 1ns/1ps
`default_nettype none
module periodic_timer
    import clk_evt_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control side
    timer_if.timer    t
);
    logic [RATE_W-1:0] count_q;

    // Period is period+1 source ticks; wraps straight into the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= {RATE_W{1'b0}};
        end else if (t.restart) begin
            count_q <= {RATE_W{1'b0}};
        end else if (t.run && t.tick) begin
            if (count_q >= t.period) begin
                count_q <= {RATE_W{1'b0}};
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    assign t.expire = t.run & t.tick & ~t.restart & (count_q >= t.period);
    assign t.count  = count_q;

    a_rate_restart: assert property (@(posedge pclk) disable iff (!presetn)
        t.restart |=> (count_q == {RATE_W{1'b0}}))
        else $error("timer not restarted by rate write");
    a_halt_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!t.run && !t.restart) |=> $stable(count_q))
        else $error("timer moved while halted");
endmodule : periodic_timer
`default_nettype wire

// >>> logic/clock_unit_event_logic.sv
`timescale 1ns/1ps
`default_nettype none
module clock_unit_event_logic
    import clk_evt_pkg::*;
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Timer clock sources, sampled
    input  wire logic                 internal_ref_clock,
    input  wire logic                 oscillator_clock,
    // Analog and PLL status, asynchronous
    input  wire logic                 pll_lock,
    input  wire logic                 vdda_below_assert,
    input  wire logic                 vdda_above_deassert,
    // Power modes, from logic on pclk
    input  wire logic                 stop_mode,
    input  wire logic                 full_performance_mode,
    // Status and configuration out
    output logic                      oscillator_up_status,
    output logic                      low_voltage_status,
    output logic      [PLL_CFG_W-1:0] pll_config,
    // Interrupts
    output logic                      periodic_timer_interrupt,
    output logic                      lock_irq,
    output logic                      osc_irq,
    output logic                      lv_irq,
    output logic                      irq
);

    // --------------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------------
    logic [CTRL_W-1:0]    ctrl_q;
    logic [RATE_W-1:0]    timer_rate_register_q;
    logic [EV_W-1:0]      flags_q;
    logic [EV_W-1:0]      flags_d;
    logic [EV_W-1:0]      enable_q;
    logic [EV_W-1:0]      ev_set;
    logic [EV_W-1:0]      ev_clr;
    logic [PLL_CFG_W-1:0] pll_cfg_q;
    logic                 osc_up_q;
    logic                 osc_up_d;
    logic                 lvds_q;
    logic                 lvds_d;
    logic [31:0]          prdata_q;
    logic                 lock_lvl;
    logic                 lock_chg;
    logic                 below_lvl;
    logic                 above_lvl;
    logic                 irc_rise;
    logic                 osc_rise;
    logic                 wr_acc;
    logic                 rd_setup;
    logic                 rate_wr;
    logic                 cfg_wr;
    logic                 full_stop;
    logic                 timer_keep;
    logic [ST_W-1:0]      state_vec;

    timer_if tif ();

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        reg_hit = (a == OFF_CTRL) || (a == OFF_RATE) || (a == OFF_FLAGS) ||
                  (a == OFF_ENABLE) || (a == OFF_STATE) || (a == OFF_PLL_CFG);
    endfunction

    function automatic logic [EV_W-1:0] sticky(input logic [EV_W-1:0] q,
                                               input logic [EV_W-1:0] set,
                                               input logic [EV_W-1:0] clr);
        sticky = (q & ~clr) | set;
    endfunction

    // --------------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------------
    signal_sync u_sync_irc (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (internal_ref_clock),
        .level    (),
        .rise     (irc_rise),
        .change   ()
    );

    signal_sync u_sync_osc (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (oscillator_clock),
        .level    (),
        .rise     (osc_rise),
        .change   ()
    );

    signal_sync u_sync_lock (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pll_lock),
        .level    (lock_lvl),
        .rise     (),
        .change   (lock_chg)
    );

    signal_sync u_sync_below (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (vdda_below_assert),
        .level    (below_lvl),
        .rise     (),
        .change   ()
    );

    signal_sync u_sync_above (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (vdda_above_deassert),
        .level    (above_lvl),
        .rise     (),
        .change   ()
    );

    // --------------------------------------------------------------------
    // APB slave
    // --------------------------------------------------------------------
    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign rate_wr  = wr_acc && (paddr == OFF_RATE);
    assign cfg_wr   = wr_acc && (paddr == OFF_PLL_CFG);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~reg_hit(paddr);
    assign prdata   = prdata_q;
    assign state_vec = {lvds_q, osc_up_q, lock_lvl};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q                <= CTRL_RST;
            timer_rate_register_q <= RATE_RST;
            enable_q              <= EV_RST;
            pll_cfg_q             <= PLL_CFG_RST;
        end else if (wr_acc) begin
            case (paddr)
                OFF_CTRL:    ctrl_q                <= pwdata[CTRL_W-1:0];
                OFF_RATE:    timer_rate_register_q <= pwdata[RATE_W-1:0];
                OFF_ENABLE:  enable_q              <= pwdata[EV_W-1:0];
                OFF_PLL_CFG: pll_cfg_q             <= pwdata[PLL_CFG_W-1:0];
                default:     ;
            endcase
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RDATA_RST;
        end else if (rd_setup) begin
            case (paddr)
                OFF_CTRL:    prdata_q <= {{(32-CTRL_W){1'b0}}, ctrl_q};
                OFF_RATE:    prdata_q <= {{(32-RATE_W){1'b0}}, timer_rate_register_q};
                OFF_FLAGS:   prdata_q <= {{(32-EV_W){1'b0}}, flags_q};
                OFF_ENABLE:  prdata_q <= {{(32-EV_W){1'b0}}, enable_q};
                OFF_STATE:   prdata_q <= {{(32-ST_W){1'b0}}, state_vec};
                OFF_PLL_CFG: prdata_q <= {{(32-PLL_CFG_W){1'b0}}, pll_cfg_q};
                default:     prdata_q <= RDATA_RST;
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Periodic timer
    // --------------------------------------------------------------------
    assign full_stop  = stop_mode & ~ctrl_q[CTRL_PSTOP_SEL];
    assign timer_keep = ctrl_q[CTRL_PSTOP_SEL] & ctrl_q[CTRL_SRC_SEL] & ctrl_q[CTRL_OSC_PSTOP];

    assign tif.tick    = ctrl_q[CTRL_SRC_SEL] ? osc_rise : irc_rise;
    assign tif.run     = ~stop_mode | timer_keep;
    assign tif.restart = rate_wr;
    assign tif.period  = timer_rate_register_q;

    periodic_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (tif)
    );

    // --------------------------------------------------------------------
    // Oscillator-up and low-voltage status
    // --------------------------------------------------------------------
    always_comb begin
        osc_up_d = osc_up_q;
        if (!ctrl_q[CTRL_OSC_EN] || !lock_lvl || cfg_wr || full_stop) begin
            osc_up_d = 1'b0;
        end else if (lock_lvl) begin
            osc_up_d = 1'b1;
        end
    end

    always_comb begin
        lvds_d = lvds_q;
        if (full_performance_mode) begin
            if (below_lvl) begin
                lvds_d = 1'b1;
            end else if (above_lvl) begin
                lvds_d = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_up_q <= 1'b0;
            lvds_q   <= 1'b0;
        end else begin
            osc_up_q <= osc_up_d;
            lvds_q   <= lvds_d;
        end
    end

    // --------------------------------------------------------------------
    // Sticky flags, set wins over write-one-to-clear
    // --------------------------------------------------------------------
    always_comb begin
        ev_set           = EV_RST;
        ev_set[EV_TIMER] = tif.expire;
        ev_set[EV_LOCK]  = lock_chg;
        ev_set[EV_OSC]   = osc_up_d ^ osc_up_q;
        ev_set[EV_LV]    = lvds_d ^ lvds_q;
        ev_clr           = (wr_acc && (paddr == OFF_FLAGS)) ? pwdata[EV_W-1:0] : EV_RST;
        flags_d          = sticky(flags_q, ev_set, ev_clr);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= EV_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // --------------------------------------------------------------------
    // Interrupt outputs
    // --------------------------------------------------------------------
    assign periodic_timer_interrupt = flags_q[EV_TIMER] & enable_q[EV_TIMER];
    assign lock_irq = flags_q[EV_LOCK] & enable_q[EV_LOCK];
    assign osc_irq  = flags_q[EV_OSC] & enable_q[EV_OSC];
    assign lv_irq   = flags_q[EV_LV] & enable_q[EV_LV];
    assign irq      = |(flags_q & enable_q);

    assign oscillator_up_status = osc_up_q;
    assign low_voltage_status   = lvds_q;
    assign pll_config           = pll_cfg_q;

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_src_select: assert property (
        ctrl_q[CTRL_SRC_SEL] && !osc_rise |-> !tif.tick)
        else $error("tick taken from unselected clock");
    a_stop_halt: assert property (
        stop_mode && !timer_keep |-> !tif.run)
        else $error("timer runs in stop mode");
    a_period_flag: assert property (
        tif.expire |=> flags_q[EV_TIMER] && tif.count == 0)
        else $error("period end did not set flag and wrap");
    a_periodic_irq: assert property (
        periodic_timer_interrupt == (flags_q[EV_TIMER] && enable_q[EV_TIMER]))
        else $error("periodic interrupt missing");
    a_lock_flag: assert property (
        lock_chg |=> flags_q[EV_LOCK])
        else $error("lock change not flagged");
    a_lock_irq_off: assert property (
        !enable_q[EV_LOCK] |-> !lock_irq)
        else $error("lock interrupt while disabled");
    a_lock_hold: assert property (
        flags_q[EV_LOCK] && !ev_clr[EV_LOCK] |=> flags_q[EV_LOCK])
        else $error("lock flag lost without write one");
    a_osc_disabled: assert property (
        !ctrl_q[CTRL_OSC_EN] |=> !osc_up_q)
        else $error("oscillator up while disabled");
    a_up_after_lock: assert property (
        $rose(osc_up_q) |-> $past(lock_lvl))
        else $error("oscillator up before lock");
    a_osc_flag: assert property (
        $changed(osc_up_q) |-> flags_q[EV_OSC])
        else $error("oscillator change not flagged");
    a_cfg_clear: assert property (
        cfg_wr || !lock_lvl |=> !osc_up_q)
        else $error("oscillator up kept after config change");
    a_osc_irq_off: assert property (
        !enable_q[EV_OSC] |-> !osc_irq)
        else $error("oscillator interrupt while disabled");
    a_lv_set: assert property (
        full_performance_mode && below_lvl |=> lvds_q)
        else $error("low voltage status not set");
    a_lv_clear: assert property (
        full_performance_mode && !below_lvl && above_lvl |=> !lvds_q)
        else $error("low voltage status not cleared");
    a_lv_flag: assert property (
        $changed(lvds_q) |-> flags_q[EV_LV])
        else $error("low voltage change not flagged");
    a_irq_level: assert property (
        irq == (periodic_timer_interrupt | lock_irq | osc_irq | lv_irq))
        else $error("combined interrupt mismatch");
    a_w1c_clear: assert property (
        ev_clr[EV_TIMER] && !ev_set[EV_TIMER] |=> !flags_q[EV_TIMER])
        else $error("timer flag not cleared by write one");

    c_period_expire: cover property (tif.expire && enable_q[EV_TIMER]);
    c_lock_loss:     cover property (lock_chg && !lock_lvl);
    c_osc_up_rise:   cover property ($rose(osc_up_q));
    c_full_stop:     cover property (full_stop && $fell(osc_up_q));
    c_lv_assert:     cover property ($rose(lvds_q) ##[1:50] irq);

endmodule : clock_unit_event_logic
`default_nettype wire

// >>> dv/clock_unit_event_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Compare macro
// ----------------------------------------------------------------------
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end

module clock_unit_event_logic_bench;
    import clk_evt_pkg::*;

    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [ADDR_W-1:0]    paddr = '0;
    logic [31:0]          pwdata = '0;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 irc = 1'b0;
    logic                 osc = 1'b0;
    logic                 pll_lock = 1'b0;
    logic                 below = 1'b0;
    logic                 above = 1'b0;
    logic                 stop_mode = 1'b0;
    logic                 full_perf = 1'b0;
    logic                 osc_up;
    logic                 lv_status;
    logic [PLL_CFG_W-1:0] pll_config;
    logic                 tmr_irq;
    logic                 lock_irq;
    logic                 osc_irq;
    logic                 lv_irq;
    logic                 irq;
    int                   fails = 0;
    int                   samples_checked = 0;
    logic [31:0]          rd;
    logic                 err;

    always #20 pclk = ~pclk;

    clock_unit_event_logic i_clock_unit_event_logic (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .internal_ref_clock(irc),
        .oscillator_clock(osc), .pll_lock(pll_lock), .vdda_below_assert(below),
        .vdda_above_deassert(above), .stop_mode(stop_mode),
        .full_performance_mode(full_perf), .oscillator_up_status(osc_up),
        .low_voltage_status(lv_status), .pll_config(pll_config),
        .periodic_timer_interrupt(tmr_irq), .lock_irq(lock_irq),
        .osc_irq(osc_irq), .lv_irq(lv_irq), .irq(irq)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fails++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, exp)
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Source edges slow enough for the two-stage sampler
    task automatic ticks(input int n, input bit use_osc);
        repeat (n) begin
            if (use_osc) osc <= 1'b1; else irc <= 1'b1;
            idle(4);
            if (use_osc) osc <= 1'b0; else irc <= 1'b0;
            idle(4);
        end
        idle(6);
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        idle(8);
        presetn <= 1'b1;
        idle(3);
        rd_chk(OFF_CTRL, 32'h0000_0000);
        rd_chk(OFF_RATE, 32'h0000_0000);
        rd_chk(OFF_FLAGS, 32'h0000_0000);
        rd_chk(OFF_ENABLE, 32'h0000_0000);
        rd_chk(OFF_STATE, 32'h0000_0000);
        rd_chk(OFF_PLL_CFG, 32'h0000_0000);
        rd_chk(12'h020, 32'h0000_0000);
        `CHK(err, 1'b1)
        wr(OFF_STATE, 32'h0000_0007);
        rd_chk(OFF_STATE, 32'h0000_0000);
        // Lock change flag and its mask
        pll_lock <= 1'b1;
        idle(6);
        rd_chk(OFF_FLAGS, 32'h0000_0002);
        `CHK(lock_irq, 1'b0)
        wr(OFF_FLAGS, 32'h0000_0000);
        rd_chk(OFF_FLAGS, 32'h0000_0002);
        wr(OFF_ENABLE, 32'h0000_0002);
        idle(1);
        `CHK({lock_irq, irq}, 2'b11)
        wr(OFF_FLAGS, 32'h0000_0002);
        idle(1);
        rd_chk(OFF_FLAGS, 32'h0000_0000);
        `CHK({lock_irq, irq}, 2'b00)
        // Oscillator-up status
        `CHK(osc_up, 1'b0)
        wr(OFF_CTRL, 32'h0000_0008);
        idle(3);
        `CHK(osc_up, 1'b1)
        rd_chk(OFF_FLAGS, 32'h0000_0004);
        `CHK(osc_irq, 1'b0)
        wr(OFF_ENABLE, 32'h0000_0004);
        idle(1);
        `CHK({osc_irq, irq}, 2'b11)
        wr(OFF_FLAGS, 32'h0000_000F);
        wr(OFF_PLL_CFG, 32'h0000_005A);
        idle(3);
        `CHK(pll_config, 8'h5A)
        rd_chk(OFF_FLAGS, 32'h0000_0004);
        wr(OFF_FLAGS, 32'h0000_000F);
        pll_lock <= 1'b0;
        idle(6);
        `CHK(osc_up, 1'b0)
        rd_chk(OFF_FLAGS, 32'h0000_0006);
        pll_lock <= 1'b1;
        idle(6);
        wr(OFF_FLAGS, 32'h0000_000F);
        wr(OFF_CTRL, 32'h0000_0000);
        idle(3);
        `CHK(osc_up, 1'b0)
        rd_chk(OFF_FLAGS, 32'h0000_0004);
        wr(OFF_FLAGS, 32'h0000_0004);
        rd_chk(OFF_FLAGS, 32'h0000_0000);
        // Low voltage status
        below <= 1'b1;
        idle(6);
        `CHK(lv_status, 1'b0)
        full_perf <= 1'b1;
        idle(4);
        `CHK(lv_status, 1'b1)
        wr(OFF_ENABLE, 32'h0000_0008);
        idle(1);
        `CHK({lv_irq, irq}, 2'b11)
        wr(OFF_FLAGS, 32'h0000_0008);
        below <= 1'b0;
        above <= 1'b1;
        idle(6);
        `CHK(lv_status, 1'b0)
        rd_chk(OFF_FLAGS, 32'h0000_0008);
        wr(OFF_FLAGS, 32'h0000_0008);
        idle(1);
        `CHK(lv_irq, 1'b0)
        // Periodic timer, three ticks a period
        wr(OFF_ENABLE, 32'h0000_0001);
        wr(OFF_RATE, 32'h0000_0002);
        ticks(2, 1'b0);
        rd_chk(OFF_FLAGS, 32'h0000_0000);
        ticks(1, 1'b0);
        rd_chk(OFF_FLAGS, 32'h0000_0001);
        `CHK({tmr_irq, irq}, 2'b11)
        wr(OFF_FLAGS, 32'h0000_0001);
        ticks(3, 1'b0);
        rd_chk(OFF_FLAGS, 32'h0000_0001);
        wr(OFF_FLAGS, 32'h0000_0001);
        ticks(2, 1'b0);
        wr(OFF_RATE, 32'h0000_0002);
        ticks(2, 1'b0);
        rd_chk(OFF_FLAGS, 32'h0000_0000);
        ticks(1, 1'b0);
        rd_chk(OFF_FLAGS, 32'h0000_0001);
        wr(OFF_FLAGS, 32'h0000_0001);
        ticks(3, 1'b1);
        rd_chk(OFF_FLAGS, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0001);
        wr(OFF_RATE, 32'h0000_0002);
        ticks(3, 1'b1);
        rd_chk(OFF_FLAGS, 32'h0000_0001);
        wr(OFF_FLAGS, 32'h0000_0001);
        stop_mode <= 1'b1;
        wr(OFF_RATE, 32'h0000_0002);
        ticks(3, 1'b1);
        rd_chk(OFF_FLAGS, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0007);
        wr(OFF_RATE, 32'h0000_0002);
        ticks(3, 1'b1);
        rd_chk(OFF_FLAGS, 32'h0000_0001);
        wr(OFF_FLAGS, 32'h0000_0001);
        idle(1);
        `CHK({tmr_irq, irq}, 2'b00)
        // Entering full stop drops oscillator-up
        stop_mode <= 1'b0;
        wr(OFF_CTRL, 32'h0000_0008);
        idle(3);
        `CHK(osc_up, 1'b1)
        wr(OFF_FLAGS, 32'h0000_000F);
        stop_mode <= 1'b1;
        idle(3);
        `CHK(osc_up, 1'b0)
        rd_chk(OFF_FLAGS, 32'h0000_0004);
        end_sim();
    end
endmodule // clock_unit_event_logic_bench
`default_nettype wire
